// ==== verilog/qpm_pkg.sv ====
// qpm_pkg: shared constants for the quad channel pin function multiplexer
// assumes a single 25 MHz clock domain and no register bus
package qpm_pkg;

  // ****************************************************************
  // pin functions
  // ****************************************************************
  typedef enum logic [1:0] {
    QPM_FN_UART,
    QPM_FN_BITBANG,
    QPM_FN_ENGINE
  } qpm_func_t;

  localparam int unsigned NUM_CHANNELS   = 4;
  localparam int unsigned NUM_ENGINES    = 2;
  localparam int unsigned PINS_PER_CHAN  = 8;

  // ****************************************************************
  // uart pin positions
  // ****************************************************************
  localparam int unsigned UART_TX_BIT    = 0;
  localparam int unsigned UART_RX_BIT    = 1;
  localparam int unsigned UART_RTS_BIT   = 2;
  localparam int unsigned UART_CTS_BIT   = 3;
  localparam int unsigned UART_DTR_BIT   = 4;
  localparam int unsigned UART_DSR_BIT   = 5;
  localparam int unsigned UART_DCD_BIT   = 6;
  localparam int unsigned UART_RING_BIT  = 7;

  // ****************************************************************
  // engine pin positions
  // ****************************************************************
  localparam int unsigned ENG_CLK_BIT    = 0;
  localparam int unsigned ENG_DOUT_BIT   = 1;
  localparam int unsigned ENG_DIN_BIT    = 2;
  localparam int unsigned ENG_SEL_BIT    = 3;
  localparam int unsigned ENG_GP_LSB     = 4;
  localparam int unsigned ENG_GP_WIDTH   = 4;

  // ****************************************************************
  // reset values (enable is active low: all ones = all released)
  // ****************************************************************
  localparam logic [7:0]  PIN_OUT_RST    = 8'hFF;
  localparam logic [7:0]  PIN_OE_N_RST   = 8'hFF;
  localparam logic [1:0]  FUNC_RST       = 2'h0;

  // uart mode direction: bits 0,2,4 drive; bit 7 drives only as rs485 enable
  localparam logic [7:0]  UART_OE_N      = 8'hEA;
  localparam logic [7:0]  UART_OE_N_485  = 8'h6A;
  // engine mode fixed direction for bits 3..0: 0,1,3 drive, 2 input
  localparam logic [3:0]  ENG_OE_N_LOW   = 4'h4;

endpackage : qpm_pkg

// ==== verilog/qpm_wake.sv ====
// qpm_wake: remote wake request from the ring input during suspend
// assumes ring input is synchronous to clk_i
`timescale 1ns/1ps
module qpm_wake (
  input  wire logic clk_i,          // system clock
  input  wire logic reset_i,        // async reset, active high
  input  wire logic en_i,           // clock enable
  input  wire logic suspend_i,      // usb link is suspended
  input  wire logic wake_enable_i,  // remote wake-up configured
  input  wire logic pulldown_en_i,  // suspend pull-down configured
  input  wire logic ring_active_i,  // ring line usable (not rs485 mode)
  input  wire logic ring_wake_n_i,  // ring line level, active low
  output logic      wake_o          // one-cycle resume request
);

  logic ring_q;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ring_q <= 1'b0;
    else if (en_i)
      ring_q <= ~ring_wake_n_i;
  end

  // fire on the falling edge of the ring line while suspended
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      wake_o <= 1'b0;
    else if (en_i)
      wake_o <= suspend_i & wake_enable_i & ~pulldown_en_i
                & ring_active_i & ~ring_wake_n_i & ~ring_q;
  end

endmodule : qpm_wake

// ==== verilog/qpm_chan.sv ====
// qpm_chan: one channel's pin routing for uart, bit-bang and engine functions
// assumes all inputs synchronous to clk_i
`timescale 1ns/1ps
module qpm_chan #(
  parameter bit HAS_ENGINE = 1'b1
) (
  input  wire logic       clk_i,         // system clock
  input  wire logic       reset_i,       // async reset, active high
  input  wire logic       en_i,          // clock enable
  input  wire logic [1:0] func_i,        // selected pin function
  input  wire logic       rs485_sel_i,   // bit 7 is rs485 drive enable
  input  wire logic       uart_tx_i,     // uart transmit data
  input  wire logic       uart_rts_n_i,  // uart request to send
  input  wire logic       uart_dtr_n_i,  // uart terminal ready
  input  wire logic       uart_de_i,     // uart rs485 drive enable
  input  wire logic [7:0] bb_out_i,      // bit-bang output data
  input  wire logic [7:0] bb_oe_n_i,     // bit-bang enables, low drives
  input  wire logic       eng_clk_i,     // engine clock
  input  wire logic       eng_dout_i,    // engine data out
  input  wire logic       eng_sel_i,     // engine select line
  input  wire logic [3:0] eng_gp_out_i,  // engine general lines out
  input  wire logic [3:0] eng_gp_oe_n_i, // engine general enables, low drives
  output logic [7:0]      pin_out_o,     // pin output levels
  output logic [7:0]      pin_oe_n_o     // pin enables, low drives
);

  // ****************************************************************
  // function decode
  // ****************************************************************
  qpm_pkg::qpm_func_t fn;
  logic [7:0] out_d;
  logic [7:0] oe_n_d;

  always_comb
  begin
    fn     = qpm_pkg::qpm_func_t'(func_i);
    out_d  = qpm_pkg::PIN_OUT_RST;
    oe_n_d = qpm_pkg::PIN_OE_N_RST;
    case (fn)
      qpm_pkg::QPM_FN_UART:
      begin
        out_d[qpm_pkg::UART_TX_BIT]   = uart_tx_i;
        out_d[qpm_pkg::UART_RTS_BIT]  = uart_rts_n_i;
        out_d[qpm_pkg::UART_DTR_BIT]  = uart_dtr_n_i;
        out_d[qpm_pkg::UART_RING_BIT] = uart_de_i;
        oe_n_d = rs485_sel_i ? qpm_pkg::UART_OE_N_485 : qpm_pkg::UART_OE_N;
      end
      qpm_pkg::QPM_FN_BITBANG:
      begin
        out_d  = bb_out_i;
        oe_n_d = bb_oe_n_i;
      end
      qpm_pkg::QPM_FN_ENGINE:
      begin
        if (HAS_ENGINE)
        begin
          out_d[qpm_pkg::ENG_CLK_BIT]  = eng_clk_i;
          out_d[qpm_pkg::ENG_DOUT_BIT] = eng_dout_i;
          out_d[qpm_pkg::ENG_SEL_BIT]  = eng_sel_i;
          out_d[qpm_pkg::ENG_GP_LSB +: qpm_pkg::ENG_GP_WIDTH] = eng_gp_out_i;
          oe_n_d[3:0] = qpm_pkg::ENG_OE_N_LOW;
          oe_n_d[qpm_pkg::ENG_GP_LSB +: qpm_pkg::ENG_GP_WIDTH] = eng_gp_oe_n_i;
        end
      end
      default:
      begin
        out_d  = qpm_pkg::PIN_OUT_RST;
        oe_n_d = qpm_pkg::PIN_OE_N_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_out_o  <= qpm_pkg::PIN_OUT_RST;
      pin_oe_n_o <= qpm_pkg::PIN_OE_N_RST;
    end
    else if (en_i)
    begin
      pin_out_o  <= out_d;
      pin_oe_n_o <= oe_n_d;
    end
  end

endmodule : qpm_chan

// ==== verilog/qpm_mux.sv ====
// qpm_mux: four-channel pin function multiplexer top level
// assumes uart, bit-bang and engine logic live outside and all inputs are synchronous to clk_i
`timescale 1ns/1ps

// Contract
// - every channel can run its pins as a uart
// - uart: bit 0 transmit out, bit 1 receive in
// - uart: bit 2 request-to-send out, bit 3 clear-to-send in, active low
// - uart: bit 4 terminal-ready out, bits 5,6 set-ready and carrier in
// - ring line low in suspend with wake enabled resumes the host
// - suspend pull-down enabled blocks ring wake-up
// - bit 7 may instead be rs485 transmit enable output
// - every channel can run bit-bang, synchronous or asynchronous
// - bit-bang uses all eight pins as bidirectional data
// - only channels 0 and 1 have a serial engine, independent
// - engine supports jtag, i2c, spi or custom protocols
// - engine: bit 0 is serial clock out
// - engine: bit 1 is serial data out
// - engine: bit 2 is serial data in
// - engine: bit 3 is select output
// - engine: bits 4 to 7 are general bidirectional lines
// - channels 2,3 stay uart or bit-bang whatever channels 0,1 do
// - suspend indicator driven low while link suspended
module qpm_mux (
  input  wire logic        clk_i,            // 25 MHz system clock
  input  wire logic        reset_i,          // async reset, active high
  input  wire logic        en_i,             // clock enable, freezes all state
  input  wire logic [7:0]  func_sel_i,       // 2 bits per channel, channel 0 lowest
  input  wire logic [3:0]  rs485_sel_i,      // per channel: bit 7 is drive enable
  input  wire logic [1:0]  bb_sync_i,        // bit-bang variant per ch, shared 1 = sync
  input  wire logic        usb_suspend_i,    // usb link suspended
  input  wire logic        wake_enable_i,    // remote wake-up configured
  input  wire logic        pulldown_en_i,    // suspend pull-down configured
  input  wire logic [3:0]  uart_tx_i,        // uart transmit data per channel
  input  wire logic [3:0]  uart_rts_n_i,     // uart request to send per channel
  input  wire logic [3:0]  uart_dtr_n_i,     // uart terminal ready per channel
  input  wire logic [3:0]  rs485_drive_enable_i, // uart rs485 drive enable per channel
  input  wire logic [31:0] bb_out_i,         // bit-bang data out, 8 per channel
  input  wire logic [31:0] bb_oe_n_i,        // bit-bang enables, low drives
  input  wire logic [1:0]  eng_clk_i,        // engine clock per engine
  input  wire logic [1:0]  eng_dout_i,       // engine data out per engine
  input  wire logic [1:0]  eng_sel_i,        // engine select per engine
  input  wire logic [7:0]  eng_gp_out_i,     // engine general lines out, 4 per engine
  input  wire logic [7:0]  eng_gp_oe_n_i,    // engine general enables, low drives
  input  wire logic [7:0]  chan0_pins_i,     // channel 0 pin levels
  input  wire logic [7:0]  chan1_pins_i,     // channel 1 pin levels
  input  wire logic [7:0]  chan2_pins_i,     // channel 2 pin levels
  input  wire logic [7:0]  chan3_pins_i,     // channel 3 pin levels
  output logic [7:0]       chan0_pins_o,     // channel 0 pin drive levels
  output logic [7:0]       chan1_pins_o,     // channel 1 pin drive levels
  output logic [7:0]       chan2_pins_o,     // channel 2 pin drive levels
  output logic [7:0]       chan3_pins_o,     // channel 3 pin drive levels
  output logic [7:0]       chan0_pins_oe_n_o, // channel 0 enables, low drives
  output logic [7:0]       chan1_pins_oe_n_o, // channel 1 enables, low drives
  output logic [7:0]       chan2_pins_oe_n_o, // channel 2 enables, low drives
  output logic [7:0]       chan3_pins_oe_n_o, // channel 3 enables, low drives
  output logic [3:0]       uart_rx_o,        // uart receive data per channel
  output logic [3:0]       uart_cts_n_o,     // uart clear to send per channel
  output logic [3:0]       uart_dsr_n_o,     // uart set ready per channel
  output logic [3:0]       carrier_detect_n_o, // uart carrier detect per channel
  output logic [3:0]       ring_wake_n_o,    // uart ring line per channel
  output logic [31:0]      bb_in_o,          // bit-bang data in, 8 per channel
  output logic [1:0]       bb_sync_o,        // registered bit-bang variant
  output logic [1:0]       eng_din_o,        // engine data in per engine
  output logic [7:0]       eng_gp_in_o,      // engine general lines in
  output logic [3:0]       func_o,           // per channel: 1 = engine active
  output logic             suspend_n_o,      // low while usb suspended
  output logic             remote_wake_o     // one-cycle resume request
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // clamps an engine request on a channel without an engine back to uart
  function automatic logic [1:0] qpm_legal(input logic [1:0] f, input bit has_eng);
    logic [1:0] r;
    r = f;
    if (f == 2'(qpm_pkg::QPM_FN_ENGINE) && !has_eng)
      r = 2'(qpm_pkg::QPM_FN_UART);
    else if (f > 2'(qpm_pkg::QPM_FN_ENGINE))
      r = 2'(qpm_pkg::QPM_FN_UART);
    return r;
  endfunction : qpm_legal

  function automatic logic qpm_is(input logic [1:0] f, input qpm_pkg::qpm_func_t m);
    return f == 2'(m);
  endfunction : qpm_is

  // ****************************************************************
  // per-channel pin arrays
  // ****************************************************************
  logic [7:0] pin_in  [4];
  logic [7:0] pin_out [4];
  logic [7:0] pin_oen [4];
  logic [1:0] func_q  [4];
  logic [3:0] rs485_q;

  assign pin_in[0] = chan0_pins_i;
  assign pin_in[1] = chan1_pins_i;
  assign pin_in[2] = chan2_pins_i;
  assign pin_in[3] = chan3_pins_i;

  assign chan0_pins_o      = pin_out[0];
  assign chan1_pins_o      = pin_out[1];
  assign chan2_pins_o      = pin_out[2];
  assign chan3_pins_o      = pin_out[3];
  assign chan0_pins_oe_n_o = pin_oen[0];
  assign chan1_pins_oe_n_o = pin_oen[1];
  assign chan2_pins_oe_n_o = pin_oen[2];
  assign chan3_pins_oe_n_o = pin_oen[3];

  // ****************************************************************
  // function selection
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int c = 0; c < 4; c++)
        func_q[c] <= qpm_pkg::FUNC_RST;
      rs485_q <= 4'h0;
    end
    else if (en_i)
    begin
      for (int c = 0; c < 4; c++)
        func_q[c] <= qpm_legal(func_sel_i[2*c +: 2], c < qpm_pkg::NUM_ENGINES);
      rs485_q <= rs485_sel_i;
    end
  end

  // ****************************************************************
  // pin routing, one instance per channel
  // ****************************************************************
  for (genvar c = 0; c < 4; c++)
  begin : g_chan
    localparam int E = (c < qpm_pkg::NUM_ENGINES) ? c : 0;
    qpm_chan #(
      .HAS_ENGINE (c < qpm_pkg::NUM_ENGINES)
    ) u_chan (
      .clk_i         (clk_i),
      .reset_i       (reset_i),
      .en_i          (en_i),
      .func_i        (func_q[c]),
      .rs485_sel_i   (rs485_q[c]),
      .uart_tx_i     (uart_tx_i[c]),
      .uart_rts_n_i  (uart_rts_n_i[c]),
      .uart_dtr_n_i  (uart_dtr_n_i[c]),
      .uart_de_i     (rs485_drive_enable_i[c]),
      .bb_out_i      (bb_out_i[8*c +: 8]),
      .bb_oe_n_i     (bb_oe_n_i[8*c +: 8]),
      .eng_clk_i     (eng_clk_i[E]),
      .eng_dout_i    (eng_dout_i[E]),
      .eng_sel_i     (eng_sel_i[E]),
      .eng_gp_out_i  (eng_gp_out_i[4*E +: 4]),
      .eng_gp_oe_n_i (eng_gp_oe_n_i[4*E +: 4]),
      .pin_out_o     (pin_out[c]),
      .pin_oe_n_o    (pin_oen[c])
    );
  end

  // ****************************************************************
  // inputs back to the functions; idle values when not selected
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      uart_rx_o          <= 4'hF;
      uart_cts_n_o       <= 4'hF;
      uart_dsr_n_o       <= 4'hF;
      carrier_detect_n_o <= 4'hF;
      ring_wake_n_o      <= 4'hF;
      bb_in_o            <= 32'h0;
    end
    else if (en_i)
    begin
      for (int c = 0; c < 4; c++)
      begin
        if (qpm_is(func_q[c], qpm_pkg::QPM_FN_UART))
        begin
          uart_rx_o[c]          <= pin_in[c][qpm_pkg::UART_RX_BIT];
          uart_cts_n_o[c]       <= pin_in[c][qpm_pkg::UART_CTS_BIT];
          uart_dsr_n_o[c]       <= pin_in[c][qpm_pkg::UART_DSR_BIT];
          carrier_detect_n_o[c] <= pin_in[c][qpm_pkg::UART_DCD_BIT];
          ring_wake_n_o[c]      <= rs485_q[c] | pin_in[c][qpm_pkg::UART_RING_BIT];
        end
        else
        begin
          uart_rx_o[c]          <= 1'b1;
          uart_cts_n_o[c]       <= 1'b1;
          uart_dsr_n_o[c]       <= 1'b1;
          carrier_detect_n_o[c] <= 1'b1;
          ring_wake_n_o[c]      <= 1'b1;
        end
        bb_in_o[8*c +: 8] <= qpm_is(func_q[c], qpm_pkg::QPM_FN_BITBANG) ? pin_in[c] : 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      eng_din_o   <= 2'h0;
      eng_gp_in_o <= 8'h00;
      func_o      <= 4'h0;
      bb_sync_o   <= 2'h0;
    end
    else if (en_i)
    begin
      for (int e = 0; e < 2; e++)
      begin
        if (qpm_is(func_q[e], qpm_pkg::QPM_FN_ENGINE))
        begin
          eng_din_o[e]         <= pin_in[e][qpm_pkg::ENG_DIN_BIT];
          eng_gp_in_o[4*e +: 4] <= pin_in[e][qpm_pkg::ENG_GP_LSB +: qpm_pkg::ENG_GP_WIDTH];
        end
        else
        begin
          eng_din_o[e]          <= 1'b0;
          eng_gp_in_o[4*e +: 4] <= 4'h0;
        end
      end
      for (int c = 0; c < 4; c++)
        func_o[c] <= qpm_is(func_q[c], qpm_pkg::QPM_FN_ENGINE);
      bb_sync_o <= bb_sync_i;
    end
  end

  // ****************************************************************
  // suspend and remote wake
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      suspend_n_o <= 1'b1;
    else if (en_i)
      suspend_n_o <= ~usb_suspend_i;
  end

  logic [3:0] wake_c;

  for (genvar c = 0; c < 4; c++)
  begin : g_wake
    qpm_wake u_wake (
      .clk_i         (clk_i),
      .reset_i       (reset_i),
      .en_i          (en_i),
      .suspend_i     (usb_suspend_i),
      .wake_enable_i (wake_enable_i),
      .pulldown_en_i (pulldown_en_i),
      .ring_active_i (qpm_is(func_q[c], qpm_pkg::QPM_FN_UART) & ~rs485_q[c]),
      .ring_wake_n_i (pin_in[c][qpm_pkg::UART_RING_BIT]),
      .wake_o        (wake_c[c])
    );
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      remote_wake_o <= 1'b0;
    else if (en_i)
      remote_wake_o <= |wake_c;
  end

endmodule : qpm_mux

// ==== sim/qpm_mux_assertions.sv ====
// qpm_mux_assertions: port-level checks of the pin function multiplexer
// assumes it is bound to qpm_mux and that everything runs on clk_i
`timescale 1ns/1ps
module qpm_mux_assertions (
  input wire logic        clk_i,             // clock
  input wire logic        reset_i,           // async reset
  input wire logic        en_i,              // clock enable
  input wire logic [7:0]  func_sel_i,        // function codes
  input wire logic [3:0]  rs485_sel_i,       // bit 7 role
  input wire logic        usb_suspend_i,     // link suspended
  input wire logic        wake_enable_i,     // wake configured
  input wire logic        pulldown_en_i,     // pull-down configured
  input wire logic [3:0]  uart_tx_i,         // uart transmit
  input wire logic [1:0]  eng_clk_i,         // engine clock
  input wire logic [1:0]  eng_dout_i,        // engine data out
  input wire logic [1:0]  eng_sel_i,         // engine select
  input wire logic [31:0] bb_out_i,          // bit-bang out
  input wire logic [7:0]  chan0_pins_i,      // channel 0 levels
  input wire logic [7:0]  chan3_pins_i,      // channel 3 levels
  input wire logic [7:0]  chan0_pins_o,      // channel 0 drive
  input wire logic [7:0]  chan0_pins_oe_n_o, // channel 0 enables
  input wire logic [7:0]  chan1_pins_o,      // channel 1 drive
  input wire logic [7:0]  chan1_pins_oe_n_o, // channel 1 enables
  input wire logic [7:0]  chan2_pins_oe_n_o, // channel 2 enables
  input wire logic [7:0]  chan3_pins_o,      // channel 3 drive
  input wire logic [31:0] bb_in_o,           // bit-bang in
  input wire logic [3:0]  func_o,            // engine active
  input wire logic        suspend_n_o,       // suspend indicator
  input wire logic        remote_wake_o      // resume request
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic wake_ok = en_i && usb_suspend_i && wake_enable_i && !pulldown_en_i && func_sel_i[1:0] == 2'h0
                       && !rs485_sel_i[0];
  // each mode sequence: selection and its data held long enough for the two-stage path
  sequence uart0_s;
    (en_i && func_sel_i[1:0] == 2'h0 && $stable(uart_tx_i) && $stable(rs485_sel_i))[*4];
  endsequence
  sequence eng1_s;
    (en_i && func_sel_i[3:2] == 2'h2 && $stable({eng_clk_i, eng_dout_i, eng_sel_i}))[*4];
  endsequence
  sequence bb3_s;
    (en_i && func_sel_i[7:6] == 2'h1 && $stable(bb_out_i) && $stable(chan3_pins_i))[*4];
  endsequence
  sequence ring_fall_s;
    wake_ok[*3] ##0 chan0_pins_i[7] ##1 (wake_ok && !chan0_pins_i[7]);
  endsequence
  a_uart_tx_route: assert property (uart0_s |-> chan0_pins_o[0] == uart_tx_i[0])
    else $error("uart transmit not on pin 0");
  a_uart_dir_set: assert property (uart0_s |-> chan0_pins_oe_n_o == (rs485_sel_i[0] ? 8'h6A : 8'hEA))
    else $error("uart pin directions wrong");
  a_eng_out_route: assert property (eng1_s |-> chan1_pins_o[0] == eng_clk_i[1] && chan1_pins_o[1] == eng_dout_i[1]
    && chan1_pins_o[3] == eng_sel_i[1] && chan1_pins_oe_n_o[3:0] == 4'h4)
    else $error("engine outputs not routed");
  a_bb_pin_route: assert property (bb3_s |-> chan3_pins_o == bb_out_i[31:24] && bb_in_o[31:24] == chan3_pins_i)
    else $error("bit-bang lines not routed");
  a_eng_ch2_fold: assert property ((en_i && func_sel_i[5:4] == 2'h2)[*4] |-> !func_o[2]
    && chan2_pins_oe_n_o[3:0] == 4'hA)
    else $error("channel 2 took the engine");
  a_suspend_follows: assert property ((en_i && $stable(usb_suspend_i))[*3] |-> suspend_n_o == !usb_suspend_i)
    else $error("suspend indicator wrong");
  a_ring_wake_pulse: assert property (ring_fall_s |-> ##[1:3] remote_wake_o)
    else $error("ring fall gave no resume");
  a_pulldown_block: assert property ((en_i && (pulldown_en_i || !usb_suspend_i))[*4] |-> !remote_wake_o)
    else $error("resume while blocked");
endmodule : qpm_mux_assertions

bind qpm_mux qpm_mux_assertions u_chk (.*);

// ==== sim/qpm_far_end.sv ====
// qpm_far_end: peripherals on the 32 pins of the four channels
// assumes a released pin carries the peripheral level and a driven pin the device level
`timescale 1ns/1ps
module qpm_far_end (
  input  wire logic [31:0] pins_i,  // device drive levels
  input  wire logic [31:0] oe_n_i,  // device enables, low drives
  input  wire logic [31:0] drive_i, // peripheral levels
  output logic [31:0]      level_o  // resolved wire levels
);
  // ring line and every other released line follow the peripheral
  assign level_o = (pins_i & ~oe_n_i) | (drive_i & oe_n_i);
endmodule : qpm_far_end

// ==== sim/qpm_mux_tb_top.sv ====
// qpm_mux_tb_top: self-checking bench for the pin function multiplexer
// assumes qpm_mux with the checker bound and qpm_far_end on the pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module qpm_mux_tb_top;
  logic clk_i = 1'b0, reset_i = 1'b1, en_i = 1'b1, usb_suspend_i = 1'b0, wake_enable_i = 1'b0, pulldown_en_i = 1'b0;
  logic [7:0] func_sel_i = 8'h00, eng_gp_out_i = 8'h00, eng_gp_oe_n_i = 8'hFF, m_fs = 8'h00;
  logic [3:0] rs485_sel_i = 4'h0, uart_tx_i = 4'hF, uart_rts_n_i = 4'hF, uart_dtr_n_i = 4'hF, rs485_drive_enable_i = 4'h0;
  logic [1:0] bb_sync_i = 2'h0, eng_clk_i = 2'h0, eng_dout_i = 2'h0, eng_sel_i = 2'h0;
  logic [31:0] bb_out_i = 32'h0, bb_oe_n_i = 32'hFFFFFFFF, far_v = 32'hFFFFFFFF;
  wire [7:0] chan0_pins_o, chan1_pins_o, chan2_pins_o, chan3_pins_o, eng_gp_in_o;
  wire [7:0] chan0_pins_oe_n_o, chan1_pins_oe_n_o, chan2_pins_oe_n_o, chan3_pins_oe_n_o;
  wire [3:0] uart_rx_o, uart_cts_n_o, uart_dsr_n_o, carrier_detect_n_o, ring_wake_n_o, func_o;
  wire [31:0] bb_in_o, lvl, po, poe;
  wire [1:0] bb_sync_o, eng_din_o;
  wire suspend_n_o, remote_wake_o;
  int error_cnt = 0, n_compared = 0, cyc = 0, cnt;
  int exp_q[$];
  assign po = {chan3_pins_o, chan2_pins_o, chan1_pins_o, chan0_pins_o};
  assign poe = {chan3_pins_oe_n_o, chan2_pins_oe_n_o, chan1_pins_oe_n_o, chan0_pins_oe_n_o};
  always #20 clk_i = ~clk_i;
  qpm_mux dut (.*, .chan0_pins_i(lvl[7:0]), .chan1_pins_i(lvl[15:8]), .chan2_pins_i(lvl[23:16]),
               .chan3_pins_i(lvl[31:24]));
  qpm_far_end u_far (.pins_i(po), .oe_n_i(poe), .drive_i(far_v), .level_o(lvl));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // reference model: expected pins and returned inputs from the modelled function codes
  task automatic check_all(input string nm);
    int f;
    logic [7:0] eo, eoe, w;
    logic [4:0] ui, ue;
    for (int c = 0; c < 4; c++)
    begin
      f = int'(m_fs[2*c+:2]);
      if (f == 3 || (f == 2 && c > 1))
        f = 0;
      if (f == 0)
      begin
        eoe = rs485_sel_i[c] ? 8'h6A : 8'hEA;
        eo = {rs485_drive_enable_i[c], 2'h3, uart_dtr_n_i[c], 1'b1, uart_rts_n_i[c], 1'b1, uart_tx_i[c]};
      end
      else if (f == 1)
      begin
        eoe = bb_oe_n_i[8*c+:8];
        eo = bb_out_i[8*c+:8];
      end
      else
      begin
        eoe = {eng_gp_oe_n_i[4*c+:4], 4'h4};
        eo = {eng_gp_out_i[4*c+:4], eng_sel_i[c], 1'b1, eng_dout_i[c], eng_clk_i[c]};
      end
      w = (eo & ~eoe) | (far_v[8*c+:8] & eoe);
      `CHK("pin_drive", {eoe, eo & ~eoe}, {poe[8*c+:8], po[8*c+:8] & ~eoe});
      ue = (f == 0) ? {w[1], w[3], w[5], w[6], w[7] | rs485_sel_i[c]} : 5'h1F;
      ui = {uart_rx_o[c], uart_cts_n_o[c], uart_dsr_n_o[c], carrier_detect_n_o[c], ring_wake_n_o[c]};
      `CHK("uart_in", ue, ui);
      `CHK("bb_in", (f == 1) ? w : 8'h00, bb_in_o[8*c+:8]);
      `CHK("engine_on", f == 2, func_o[c]);
      if (c < 2)
        `CHK("engine_in", (f == 2) ? {w[7:4], w[2]} : 5'h00, {eng_gp_in_o[4*c+:4], eng_din_o[c]});
    end
    `CHK("suspend_n", ~usb_suspend_i, suspend_n_o);
    `CHK("bb_variant", bb_sync_i, bb_sync_o);
    $display("test %s done", nm);
  endtask : check_all

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      error_cnt++;
      end_sim;
    end
  end

  initial
  begin
    void'($urandom(45306));
    repeat (4) @(posedge clk_i);
    #2;
    reset_i = 1'b0;
    for (int i = 0; i < 48; i++)
    begin
      func_sel_i = (i < 4) ? {4{2'(i)}} : 8'($urandom);
      {uart_tx_i, uart_rts_n_i, uart_dtr_n_i, rs485_drive_enable_i, rs485_sel_i, bb_sync_i, eng_clk_i, eng_dout_i,
       eng_sel_i, eng_gp_out_i, eng_gp_oe_n_i} = 44'({$urandom, $urandom});
      bb_out_i = $urandom;
      bb_oe_n_i = $urandom;
      far_v = $urandom;
      m_fs = func_sel_i;
      tick(6);
      check_all("route");
    end
    func_sel_i = 8'h00;
    m_fs = 8'h00;
    tick(6);
    check_all("uart_all");
    // a held enable keeps the old selection although the code changes
    en_i = 1'b0;
    func_sel_i = 8'h55;
    tick(6);
    check_all("freeze");
    en_i = 1'b1;
    m_fs = 8'h55;
    tick(6);
    check_all("unfreeze");
    // a mid-run reset releases every pin and clears the bit-bang inputs and engine flags
    reset_i = 1'b1;
    tick(1);
    `CHK("reset_oe", 32'hFFFFFFFF, poe);
    `CHK("reset_in", 36'h0, {bb_in_o, func_o});
    `CHK("reset_wake", 2'h2, {suspend_n_o, remote_wake_o});
    reset_i = 1'b0;
    $display("test reset done");
    func_sel_i = 8'h00;
    m_fs = 8'h00;
    rs485_sel_i = 4'h0;
    far_v = 32'hFFFFFFFF;
    usb_suspend_i = 1'b1;
    wake_enable_i = 1'b1;
    tick(6);
    check_all("suspend");
    for (int p = 0; p < 2; p++)
    begin
      pulldown_en_i = 1'(p);
      tick(6);
      far_v[7] = 1'b0;
      cnt = 0;
      repeat (6)
      begin
        tick(1);
        cnt += (remote_wake_o === 1'b0) ? 0 : (remote_wake_o === 1'b1) ? 1 : 9;
      end
      exp_q.push_back(1 - p);
      `CHK("wake_pulses", exp_q[0], cnt);
      void'(exp_q.pop_front());
      far_v[7] = 1'b1;
      $display("test wake %0d done", p);
    end
    end_sim;
  end
endmodule : qpm_mux_tb_top
